// ### rtl/ddi_display_dram.sv
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module ddi_display_dram import ddi_pkg::*; (
	input logic ref_clk_i,
	input logic reset_i,
	input logic [AXI_AW-1:0] s_axi_awaddr,
	input logic s_axi_awvalid,
	output logic s_axi_awready,
	input logic [31:0] s_axi_wdata,
	input logic [3:0] s_axi_wstrb,
	input logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic [AXI_AW-1:0] s_axi_araddr,
	input logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input logic s_axi_rready,
	input ddi_req_t [3:0] client_req_i,
	output logic [3:0] client_ack_o,
	input ddi_req_t host_req_i,
	output logic host_ready_o,
	output logic rdata_valid_o,
	output logic [31:0] rdata_o,
	output logic row_strobe_n_o,
	output logic upper_bank_row_strobe_n_o,
	output logic [3:1] lane_strobe_n_o,
	output logic we0_n_o,
	output logic cas0_n_o,
	output logic oe_n_o,
	output logic [8:0] ma_o,
	input logic [31:0] display_memory_data_i,
	output logic [31:0] display_memory_data_o,
	output logic display_memory_data_oe_n_o,
	input logic video_clock_a_i,
	input logic video_clock_b_i,
	input logic video_clock_c_i,
	output logic video_clock_b_o,
	output logic video_clock_b_oe_n_o,
	output logic video_clock_c_o,
	output logic video_clock_c_oe_n_o,
	output logic [1:0] video_clock_sel_o,
	output ddi_bus_t bus_mode_o
);
	function automatic ddi_split_t split(input logic [18:0] a,
		input logic [1:0] org, input logic two_meg);
		ddi_split_t s;
		s = '0;
		case (org)
			ORG_W16_256K: begin
				s.row = a[17:9];
				s.col = a[8:0];
			end
			ORG_W32_256K: begin
				s.row = a[17:9];
				s.col = a[8:0];
				s.bank = two_meg & a[18];
			end
			default: begin
				s.row = {a[16], a[15:8]};
				s.col = {1'b0, a[7:0]};
			end
		endcase
		return s;
	endfunction : split

	function automatic ddi_dram_t column(input ddi_dram_t d,
		input ddi_req_t r, input ddi_split_t s, input logic [1:0] org,
		input logic style);
		ddi_dram_t o;
		logic [3:0] m;
		o = d;
		m = (org == ORG_W16_256K) ? {2'b00, r.be[1:0]} : r.be;
		if (!r.write) begin
			m = (org == ORG_W16_256K) ? 4'h3 : 4'hF;
		end
		o.ma = s.col;
		o.oe_n = r.write;
		o.data = r.data;
		o.data_oe_n = ~r.write;
		if (style) begin
			o.lane_n = r.write ? ~m[3:1] : 3'h7;
			o.we0_n = ~(r.write & m[0]);
			o.cas0_n = 1'b0;
		end else begin
			o.lane_n = ~m[3:1];
			o.cas0_n = ~m[0];
			o.we0_n = ~r.write;
		end
		return o;
	endfunction : column

	function automatic logic [3:0] pick(input ddi_req_t [NSRC-1:0] r);
		logic [3:0] p;
		p = '0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (r[i].valid) begin
				p = {1'b1, 3'(i)};
			end
		end
		return p;
	endfunction : pick

	logic [34:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
	logic [31:0] strap_reg, strap_next;
	ddi_ctrl_t ctrl_reg, ctrl_next;
	ddi_state_t st_reg, st_next;
	ddi_req_t cur_reg, cur_next, hbuf_reg, hbuf_next;
	ddi_split_t sp_reg, sp_next, psp;
	logic [2:0] src_reg, src_next;
	ddi_dram_t dram_reg, dram_next;
	logic [1:0] wait_reg, wait_next;
	logic [7:0] ref_cnt_reg, ref_cnt_next;
	logic ref_pend_reg, ref_pend_next, ref_clr;
	logic [31:0] rdata_reg, rdata_next;
	logic rvld_reg, rvld_next;
	ddi_req_t [NSRC-1:0] reqs;
	logic [3:0] pk;
	logic [NSRC-1:0] ack;
	logic style;
	logic aw_ok_reg, aw_ok_next, w_ok_reg, w_ok_next;
	logic [7:0] awa_reg, awa_next;
	logic [31:0] wd_reg, wd_next;
	logic [3:0] ws_reg, ws_next;
	logic bv_reg, bv_next, rv_reg, rv_next;
	logic [1:0] br_reg, br_next, rr_reg, rr_next;
	logic [31:0] rd_reg, rd_next;

	// pin sampling and strap capture
	always_comb begin
		filt_next = (~(s2_reg ^ s3_reg) & s3_reg)
			| ((s2_reg ^ s3_reg) & filt_reg);
		strap_next = reset_i ? filt_reg[31:0] : strap_reg;
	end
	always_ff @(posedge ref_clk_i) begin
		s1_reg <= {video_clock_c_i, video_clock_b_i, video_clock_a_i,
			display_memory_data_i};
		s2_reg <= s1_reg;
		s3_reg <= s2_reg;
		filt_reg <= filt_next;
		strap_reg <= strap_next;
	end

	assign style = strap_reg[STRAP_STROBE];
	assign reqs = {client_req_i[3], hbuf_reg, client_req_i[2:0]};
	assign pk = pick(reqs);
	assign psp = split(reqs[pk[2:0]].addr, ctrl_reg.org, ctrl_reg.two_meg);
	assign ack = (st_reg == ST_COL) ? NSRC'(5'h01 << src_reg) : '0;
	assign client_ack_o = {ack[SRC_FONT], ack[SRC_DRAW], ack[SRC_CURSOR],
		ack[SRC_DISP]};

	// access sequencer, one column per request
	always_comb begin
		st_next = st_reg;
		cur_next = cur_reg;
		src_next = src_reg;
		sp_next = sp_reg;
		dram_next = dram_reg;
		wait_next = wait_reg;
		rdata_next = rdata_reg;
		rvld_next = 1'b0;
		ref_clr = 1'b0;
		case (st_reg)
			ST_IDLE: begin
				if (ref_pend_reg) begin
					ref_clr = 1'b1;
					dram_next = DRAM_IDLE;
					dram_next.cas0_n = 1'b0;
					dram_next.lane_n = style ? 3'h7 : 3'h0;
					st_next = ST_RFC;
				end else if (pk[3]) begin
					cur_next = reqs[pk[2:0]];
					src_next = pk[2:0];
					sp_next = psp;
					dram_next.ma = psp.row;
					dram_next.ras_n = psp.bank;
					dram_next.ras_up_n = ~psp.bank;
					st_next = ST_ROW;
				end
			end
			ST_ROW: begin
				dram_next = column(dram_reg, cur_reg, sp_reg, ctrl_reg.org,
					style);
				st_next = ST_COL;
			end
			ST_COL: begin
				if (!cur_reg.write) begin
					rdata_next = display_memory_data_i;
					rvld_next = 1'b1;
				end
				dram_next = DRAM_IDLE;
				dram_next.ras_n = dram_reg.ras_n;
				dram_next.ras_up_n = dram_reg.ras_up_n;
				dram_next.ma = dram_reg.ma;
				st_next = ST_PAGE;
			end
			ST_PAGE: begin
				if (!ref_pend_reg && pk[3] && psp.bank == sp_reg.bank
					&& psp.row == sp_reg.row
					&& ((src_reg != SRC_FONT && pk[2:0] != SRC_FONT)
					|| ctrl_reg.font_page)) begin
					cur_next = reqs[pk[2:0]];
					src_next = pk[2:0];
					sp_next = psp;
					dram_next = column(dram_reg, reqs[pk[2:0]], psp,
						ctrl_reg.org, style);
					st_next = ST_COL;
				end else begin
					dram_next = DRAM_IDLE;
					wait_next = PRE_LAST;
					st_next = ST_PRE;
				end
			end
			ST_PRE: begin
				if (wait_reg == 2'h0) begin
					st_next = ST_IDLE;
				end else begin
					wait_next = wait_reg - 2'h1;
				end
			end
			ST_RFC: begin
				dram_next.ras_n = 1'b0;
				dram_next.ras_up_n = ~ctrl_reg.two_meg;
				st_next = ST_RFR;
			end
			ST_RFR: begin
				dram_next = DRAM_IDLE;
				st_next = ST_RFE;
			end
			ST_RFE: begin
				st_next = ST_IDLE;
			end
			default: begin
				dram_next = DRAM_IDLE;
				st_next = ST_IDLE;
			end
		endcase
	end
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			st_reg <= ST_IDLE;
			cur_reg <= '0;
			src_reg <= SRC_DISP;
			sp_reg <= '0;
			dram_reg <= DRAM_IDLE;
			wait_reg <= 2'h0;
			rdata_reg <= 32'h0000_0000;
			rvld_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			cur_reg <= cur_next;
			src_reg <= src_next;
			sp_reg <= sp_next;
			dram_reg <= dram_next;
			wait_reg <= wait_next;
			rdata_reg <= rdata_next;
			rvld_reg <= rvld_next;
		end
	end

	// refresh timer and host write buffer
	always_comb begin
		ref_cnt_next = (ref_cnt_reg == REF_LAST) ? 8'h00
			: ref_cnt_reg + 8'h01;
		ref_pend_next = ((ref_cnt_reg == REF_LAST) & ctrl_reg.ref_en)
			| (ref_pend_reg & ~ref_clr);
		hbuf_next = hbuf_reg;
		if (ack[SRC_HOST]) begin
			hbuf_next.valid = 1'b0;
		end
		if (host_req_i.valid && !hbuf_reg.valid) begin
			hbuf_next = host_req_i;
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			ref_cnt_reg <= 8'h00;
			ref_pend_reg <= 1'b0;
			hbuf_reg <= '0;
		end else begin
			ref_cnt_reg <= ref_cnt_next;
			ref_pend_reg <= ref_pend_next;
			hbuf_reg <= hbuf_next;
		end
	end

	// register bus slave
	always_comb begin
		aw_ok_next = aw_ok_reg;
		w_ok_next = w_ok_reg;
		awa_next = awa_reg;
		wd_next = wd_reg;
		ws_next = ws_reg;
		bv_next = bv_reg;
		br_next = br_reg;
		ctrl_next = ctrl_reg;
		rv_next = rv_reg;
		rr_next = rr_reg;
		rd_next = rd_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_ok_next = 1'b1;
			awa_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_ok_next = 1'b1;
			wd_next = s_axi_wdata;
			ws_next = s_axi_wstrb;
		end
		if (aw_ok_reg && w_ok_reg && !bv_reg) begin
			aw_ok_next = 1'b0;
			w_ok_next = 1'b0;
			bv_next = 1'b1;
			br_next = RESP_SLVERR;
			if (awa_reg == ADDR_CTRL) begin
				br_next = RESP_OKAY;
				if (ws_reg[0]) begin
					ctrl_next[7:0] = wd_reg[7:0];
				end
				if (ws_reg[1]) begin
					ctrl_next[9:8] = wd_reg[9:8];
				end
			end else if (awa_reg == ADDR_STRAP || awa_reg == ADDR_STATUS) begin
				br_next = RESP_OKAY;
			end
		end else if (bv_reg && s_axi_bready) begin
			bv_next = 1'b0;
		end
		if (s_axi_arvalid && !rv_reg) begin
			rv_next = 1'b1;
			rr_next = RESP_OKAY;
			case (s_axi_araddr)
				ADDR_CTRL: rd_next = {22'h0, ctrl_reg};
				ADDR_STRAP: rd_next = strap_reg;
				ADDR_STATUS: rd_next = {22'h0, hbuf_reg.valid,
					filt_reg[34:32], bus_mode_o, ref_pend_reg, st_reg};
				default: begin
					rd_next = 32'h0000_0000;
					rr_next = RESP_SLVERR;
				end
			endcase
		end else if (rv_reg && s_axi_rready) begin
			rv_next = 1'b0;
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			aw_ok_reg <= 1'b0;
			w_ok_reg <= 1'b0;
			awa_reg <= 8'h00;
			wd_reg <= 32'h0000_0000;
			ws_reg <= 4'h0;
			bv_reg <= 1'b0;
			br_reg <= RESP_OKAY;
			ctrl_reg <= CTRL_RESET;
			rv_reg <= 1'b0;
			rr_reg <= RESP_OKAY;
			rd_reg <= 32'h0000_0000;
		end else begin
			aw_ok_reg <= aw_ok_next;
			w_ok_reg <= w_ok_next;
			awa_reg <= awa_next;
			wd_reg <= wd_next;
			ws_reg <= ws_next;
			bv_reg <= bv_next;
			br_reg <= br_next;
			ctrl_reg <= ctrl_next;
			rv_reg <= rv_next;
			rr_reg <= rr_next;
			rd_reg <= rd_next;
		end
	end

	assign s_axi_awready = !aw_ok_reg && !bv_reg;
	assign s_axi_wready = !w_ok_reg && !bv_reg;
	assign s_axi_bvalid = bv_reg;
	assign s_axi_bresp = br_reg;
	assign s_axi_arready = !rv_reg;
	assign s_axi_rvalid = rv_reg;
	assign s_axi_rresp = rr_reg;
	assign s_axi_rdata = rd_reg;

	assign host_ready_o = !hbuf_reg.valid;
	assign rdata_valid_o = rvld_reg;
	assign rdata_o = rdata_reg;
	assign row_strobe_n_o = dram_reg.ras_n;
	assign upper_bank_row_strobe_n_o = dram_reg.ras_up_n;
	assign lane_strobe_n_o = dram_reg.lane_n;
	assign we0_n_o = dram_reg.we0_n;
	assign cas0_n_o = dram_reg.cas0_n;
	assign oe_n_o = dram_reg.oe_n;
	assign ma_o = dram_reg.ma;
	assign display_memory_data_o = dram_reg.data;
	assign display_memory_data_oe_n_o = dram_reg.data_oe_n;

	// clock routing and bus selection
	assign video_clock_b_o = ctrl_reg.vclk_b_val;
	assign video_clock_c_o = ctrl_reg.vclk_c_val;
	assign video_clock_b_oe_n_o = strap_reg[STRAP_VCLK_DIR];
	assign video_clock_c_oe_n_o = strap_reg[STRAP_VCLK_DIR];
	assign video_clock_sel_o = ctrl_reg.mclk_video ? VSEL_MCLK
		: ctrl_reg.vsel;
	assign bus_mode_o = !strap_reg[STRAP_LOCAL] ? BUS_LOCAL
		: (strap_reg[STRAP_BUS_FAMILY] ? BUS_AT : BUS_CHANNEL);
endmodule : ddi_display_dram

// ### rtl/ddi_pkg.sv
// Behaviour
// - fast page cycles in every memory organisation
// - 32-bit path from 64Kx16 DRAMs
// - 16-bit path from 256Kx4 or 256Kx16
// - 32-bit path from 256Kx4 or 256Kx16
// - page timing for draw, cursor, host, display
// - font fetches selectable page or non-page
// - CAS-before-RAS refresh of display memory
// - sequencing from memory clock, 60-100 ns DRAMs
// - host writes buffered without wait states
// - memory data pins sampled into strap register
// - strap bit 2 picks AT or channel bus
// - strap bit 11 picks local bus or the bit-2 AT/channel bus
// - other strap bits readable or clock control
// - memory clock times DRAM, video clocks video
// - video clocks b and c programmable outputs
// - memory clock selectable for video timing
// - muxed pins follow bus chosen at reset
// - strobe strap picks per-byte WE or CAS
// - upper row strobe for second megabyte only
package ddi_pkg;
	localparam int CLK_PERIOD_NS = 100;
	localparam int REFRESH_NS = 15600;
	localparam int REFRESH_CYC = REFRESH_NS / CLK_PERIOD_NS;
	localparam int PRECHARGE_NS = 60;
	localparam int PRECHARGE_CYC =
		(PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] REF_LAST = 8'(REFRESH_CYC - 1);
	localparam logic [1:0] PRE_LAST = 2'(PRECHARGE_CYC - 1);

	localparam int AXI_AW = 8;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STRAP = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam int STRAP_BUS_FAMILY = 2;
	localparam int STRAP_VCLK_DIR = 3;
	localparam int STRAP_LOCAL = 11;
	localparam int STRAP_STROBE = 17;

	localparam int NSRC = 5;
	localparam logic [2:0] SRC_DISP = 3'h0;
	localparam logic [2:0] SRC_CURSOR = 3'h1;
	localparam logic [2:0] SRC_DRAW = 3'h2;
	localparam logic [2:0] SRC_HOST = 3'h3;
	localparam logic [2:0] SRC_FONT = 3'h4;

	typedef enum logic [1:0] {
		ORG_W32_64K = 2'h0,
		ORG_W16_256K = 2'h1,
		ORG_W32_256K = 2'h2
	} ddi_org_t;

	typedef enum logic [1:0] {
		BUS_AT = 2'h0,
		BUS_CHANNEL = 2'h1,
		BUS_LOCAL = 2'h2
	} ddi_bus_t;

	localparam logic [1:0] VSEL_MCLK = 2'h3;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ROW = 3'h1,
		ST_COL = 3'h3,
		ST_PAGE = 3'h2,
		ST_PRE = 3'h6,
		ST_RFC = 3'h4,
		ST_RFR = 3'h5,
		ST_RFE = 3'h7
	} ddi_state_t;

	typedef struct packed {
		logic ref_en;
		logic vclk_c_val;
		logic vclk_b_val;
		logic mclk_video;
		logic [1:0] vsel;
		logic font_page;
		logic two_meg;
		logic [1:0] org;
	} ddi_ctrl_t;
	localparam ddi_ctrl_t CTRL_RESET = 10'h208;

	typedef struct packed {
		logic valid;
		logic write;
		logic [18:0] addr;
		logic [3:0] be;
		logic [31:0] data;
	} ddi_req_t;

	typedef struct packed {
		logic bank;
		logic [8:0] row;
		logic [8:0] col;
	} ddi_split_t;

	typedef struct packed {
		logic ras_n;
		logic ras_up_n;
		logic [3:1] lane_n;
		logic we0_n;
		logic cas0_n;
		logic oe_n;
		logic [8:0] ma;
		logic [31:0] data;
		logic data_oe_n;
	} ddi_dram_t;
	localparam ddi_dram_t DRAM_IDLE = '{ras_n: 1'b1, ras_up_n: 1'b1,
		lane_n: 3'h7, we0_n: 1'b1, cas0_n: 1'b1, oe_n: 1'b1,
		ma: 9'h000, data: 32'h0000_0000, data_oe_n: 1'b1};
endpackage : ddi_pkg

// ### tb/ddi_dram_model.sv
`timescale 1ns/1ps
module ddi_dram_model (
	input wire logic clk_i,
	input wire logic style_i,
	input wire logic ras_n_i,
	input wire logic cas0_n_i,
	input wire logic [3:1] lane_n_i,
	input wire logic we0_n_i,
	input wire logic oe_n_i,
	input wire logic [8:0] ma_i,
	input wire logic [31:0] d_i,
	output logic [31:0] q_o,
	output logic en_o
);
	logic [31:0] mem [0:262143];
	logic [8:0] row;
	logic ras_d;
	logic [3:0] cas_n;
	logic [3:0] we_n;
	assign cas_n = style_i ? {4{cas0_n_i}} : {lane_n_i, cas0_n_i};
	assign we_n = style_i ? {lane_n_i, we0_n_i} : {4{we0_n_i}};
	// row address latched at the first edge after the row strobe falls
	always @(posedge clk_i) begin
		ras_d <= ras_n_i;
		if (ras_d && !ras_n_i) row <= ma_i;
	end
	// column accesses reuse the open row until the row strobe rises
	assign en_o = !ras_n_i && !oe_n_i && !(&cas_n);
	assign q_o = mem[{row, ma_i}];
	always @(posedge clk_i) begin
		for (int i = 0; i < 4; i++) begin
			if (!ras_n_i && !cas_n[i] && !we_n[i]) begin
				mem[{row, ma_i}][8*i +: 8] <= d_i[8*i +: 8];
			end
		end
	end
endmodule : ddi_dram_model

// ### tb/ddi_display_dram_monitor.sv
`timescale 1ns/1ps
module ddi_display_dram_monitor import ddi_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire ddi_req_t [3:0] client_req_i,
	input wire logic [3:0] client_ack_o,
	input wire logic rdata_valid_o,
	input wire logic row_strobe_n_o,
	input wire logic upper_bank_row_strobe_n_o,
	input wire logic [3:1] lane_strobe_n_o,
	input wire logic we0_n_o,
	input wire logic cas0_n_o,
	input wire logic oe_n_o,
	input wire logic display_memory_data_oe_n_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	logic [3:0] vld;
	logic rows_n;
	always_comb begin
		for (int i = 0; i < 4; i++) vld[i] = client_req_i[i].valid;
	end
	assign rows_n = row_strobe_n_o && upper_bank_row_strobe_n_o;
	sequence cbr_cas;
		!cas0_n_o && rows_n && we0_n_o;
	endsequence
	sequence cbr_ras;
		!cas0_n_o && !row_strobe_n_o && we0_n_o;
	endsequence
	sequence cbr_end;
		cas0_n_o && rows_n;
	endsequence
	a_refresh_order: assert property (
		$fell(cas0_n_o) && rows_n |-> cbr_cas ##1 cbr_ras ##1 cbr_end)
		else $error("refresh strobe order wrong");
	a_refresh_we: assert property (
		!cas0_n_o && rows_n |-> we0_n_o)
		else $error("write enable low in refresh");
	a_ack_onehot: assert property ($onehot0(client_ack_o))
		else $error("two clients acknowledged");
	a_ack_requested: assert property ((client_ack_o & ~vld) == 4'h0)
		else $error("ack without request");
	a_ack_column: assert property (
		|client_ack_o |-> !(cas0_n_o && &lane_strobe_n_o) && !rows_n)
		else $error("ack outside column cycle");
	a_read_data: assert property (
		|client_ack_o && !oe_n_o |=> rdata_valid_o)
		else $error("read data not flagged");
	a_write_drive: assert property (
		!we0_n_o && !row_strobe_n_o |-> !display_memory_data_oe_n_o)
		else $error("write without data drive");
	a_oe_float: assert property (
		!oe_n_o |-> display_memory_data_oe_n_o)
		else $error("data driven during read");
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
endmodule : ddi_display_dram_monitor

bind ddi_display_dram ddi_display_dram_monitor i_mon (
	.ref_clk_i(ref_clk_i), .reset_i(reset_i),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
	.client_req_i(client_req_i), .client_ack_o(client_ack_o),
	.rdata_valid_o(rdata_valid_o), .row_strobe_n_o(row_strobe_n_o),
	.upper_bank_row_strobe_n_o(upper_bank_row_strobe_n_o),
	.lane_strobe_n_o(lane_strobe_n_o), .we0_n_o(we0_n_o),
	.cas0_n_o(cas0_n_o), .oe_n_o(oe_n_o),
	.display_memory_data_oe_n_o(display_memory_data_oe_n_o));

// ### tb/test_display_dram_interface.sv
`timescale 1ns/1ps
module test_display_dram_interface import ddi_pkg::*; ;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
	logic [31:0] wd = 32'h0, strap = 32'hFFFF_FFFF;
	logic [2:0] vck = 3'h5;
	ddi_req_t [3:0] creq = '0;
	ddi_req_t hreq = '0;
	logic awrdy, wrdy, bv, arrdy, rv, hrdy, rdv, rsn, ursn, we0, cas0;
	logic oen, mdoe, vbo, vco, vboe, vcoe, en, vbp, vcp;
	logic [1:0] bresp, rresp, vsel, r;
	logic [31:0] rdata, rdo, mdo, pin_data, mq;
	logic [3:0] ack;
	logic [3:1] lane;
	logic [8:0] ma;
	ddi_bus_t mode;
	int err_count = 0, comparisons = 0, falls = 0;
	always #50 clk = ~clk;
	always @(negedge (rsn & ursn)) falls++;
	assign pin_data = !mdoe ? mdo : en ? mq : strap;
	assign vbp = !vboe ? vbo : vck[1];
	assign vcp = !vcoe ? vco : vck[2];
	ddi_display_dram i_dut (.ref_clk_i(clk), .reset_i(rst),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awrdy),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
		.s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arrdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rv), .s_axi_rready(rr), .client_req_i(creq),
		.client_ack_o(ack), .host_req_i(hreq), .host_ready_o(hrdy),
		.rdata_valid_o(rdv), .rdata_o(rdo), .row_strobe_n_o(rsn),
		.upper_bank_row_strobe_n_o(ursn), .lane_strobe_n_o(lane),
		.we0_n_o(we0), .cas0_n_o(cas0), .oe_n_o(oen), .ma_o(ma),
		.display_memory_data_i(pin_data), .display_memory_data_o(mdo),
		.display_memory_data_oe_n_o(mdoe), .video_clock_a_i(vck[0]),
		.video_clock_b_i(vbp), .video_clock_c_i(vcp),
		.video_clock_b_o(vbo), .video_clock_b_oe_n_o(vboe),
		.video_clock_c_o(vco), .video_clock_c_oe_n_o(vcoe),
		.video_clock_sel_o(vsel), .bus_mode_o(mode));
	ddi_dram_model i_mem (.clk_i(clk), .style_i(strap[STRAP_STROBE]),
		.ras_n_i(rsn & ursn), .cas0_n_i(cas0), .lane_n_i(lane),
		.we0_n_i(we0), .oe_n_i(oen), .ma_i(ma), .d_i(pin_data), .q_o(mq),
		.en_o(en));
	task automatic chk(input string n, input logic [31:0] s, e);
		comparisons++;
		if (s !== e) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : summarize
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			output logic [1:0] rs);
		awa <= a;
		wd <= d;
		awv <= 1'h1;
		wv <= 1'h1;
		forever begin
			@(posedge clk);
			if (awrdy) awv <= 1'h0;
			if (wrdy) wv <= 1'h0;
			if (bv && br) begin
				rs = bresp;
				br <= 1'h0;
				break;
			end
			if (bv) br <= 1'h1;
		end
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
			output logic [1:0] rs);
		ara <= a;
		arv <= 1'h1;
		rr <= 1'h1;
		forever begin
			@(posedge clk);
			if (arrdy) arv <= 1'h0;
			if (rv) begin
				d = rdata;
				rs = rresp;
				rr <= 1'h0;
				break;
			end
		end
		@(posedge clk);
	endtask : rd
	task automatic wack(output logic [3:0] v);
		v = 4'h0;
		for (int n = 0; n < 400 && v == 4'h0; n++) begin
			@(posedge clk);
			v = ack;
		end
		chk("ack_seen", |v, 1'h1);
	endtask : wack
	task automatic cop(input int i, input logic w, input logic [18:0] a,
			input logic [31:0] d, output logic [31:0] q,
			output logic [1:0] rs);
		logic [3:0] v;
		creq[i] <= '{1'h1, w, a, 4'hF, d};
		wack(v);
		rs = {ursn, rsn};
		creq[i].valid <= 1'h0;
		@(posedge clk);
		q = rdo;
		chk("rdata_valid", rdv, !w);
	endtask : cop
	task automatic t_strap();
		logic [31:0] sv [3] = '{32'hFFFF_FFFF, 32'hFFFF_FFFB,
			32'hFFFD_F7F7};
		ddi_bus_t bm [3] = '{BUS_AT, BUS_CHANNEL, BUS_LOCAL};
		logic [31:0] d;
		for (int k = 0; k < 3; k++) begin
			strap <= sv[k];
			rst <= 1'h1;
			repeat (6) @(posedge clk);
			chk("reset_idle", {rsn, ursn, cas0, oen, mdoe}, 5'h1F);
			rst <= 1'h0;
			@(posedge clk);
			chk("bus_mode", mode, bm[k]);
			chk("vclk_dir", vboe, sv[k][3]);
			rd(ADDR_STRAP, d, r);
			chk("strap", d, sv[k]);
		end
		$display("t_strap done");
	endtask : t_strap
	task automatic t_regs();
		logic [31:0] d;
		rd(ADDR_CTRL, d, r);
		chk("ctrl_reset", d, 32'h0000_0208);
		rd(ADDR_STATUS, d, r);
		chk("video_clocks", d[8:6], 3'h1);
		wr(ADDR_CTRL, 32'h0000_01D0, r);
		chk("clock_sel", {vsel, vbo, vco}, 4'hF);
		rd(ADDR_CTRL, d, r);
		chk("ctrl_rw", d, 32'h0000_01D0);
		wr(ADDR_CTRL, 32'h0000_0010, r);
		chk("clock_sel", {vsel, vbo, vco}, 4'h4);
		wr(8'h0C, 32'h0, r);
		chk("wr_unmapped", r, RESP_SLVERR);
		rd(8'h0C, d, r);
		chk("rd_unmapped", r, RESP_SLVERR);
		chk("rd_zero", d, 32'h0);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_page(input int i, input logic w, input int e);
		int f;
		logic [3:0] v;
		logic [31:0] d;
		f = falls;
		for (int k = 0; k < 4; k++) begin
			creq[i] <= '{1'h1, w, 19'(k), 4'hF, 32'hC0DE_0000 + 32'(k)};
			wack(v);
		end
		creq[i].valid <= 1'h0;
		@(posedge clk);
		chk("row_opens", falls - f, e);
		for (int k = 0; k < 4; k++) begin
			cop(0, 1'h0, 19'(k), 32'h0, d, r);
			chk("page_data", d, 32'hC0DE_0000 + 32'(k));
		end
		$display("t_page done");
	endtask : t_page
	task automatic t_prio();
		logic [3:0] v;
		logic [31:0] d;
		creq[0] <= '{1'h1, 1'h0, 19'h00000, 4'hF, 32'h0};
		creq[2] <= '{1'h1, 1'h0, 19'h00001, 4'hF, 32'h0};
		creq[3] <= '{1'h1, 1'h0, 19'h00002, 4'hF, 32'h0};
		hreq <= '{1'h1, 1'h1, 19'h00010, 4'hF, 32'h600D_F00D};
		@(posedge clk);
		chk("host_taken", hrdy, 1'h1);
		hreq.valid <= 1'h0;
		wack(v);
		chk("first_ack", v, 4'h1);
		creq[0].valid <= 1'h0;
		wack(v);
		chk("second_ack", v, 4'h4);
		creq[2].valid <= 1'h0;
		wack(v);
		chk("font_ack", v, 4'h8);
		chk("host_done", hrdy, 1'h1);
		creq[3].valid <= 1'h0;
		@(posedge clk);
		cop(0, 1'h0, 19'h00010, 32'h0, d, r);
		chk("host_data", d, 32'h600D_F00D);
		$display("t_prio done");
	endtask : t_prio
	task automatic t_bank();
		logic [1:0] rs;
		logic [31:0] d;
		wr(ADDR_CTRL, 32'h0000_0006, r);
		cop(2, 1'h1, 19'h40005, 32'h0BAD_CAFE, d, rs);
		chk("upper_strobe", rs, 2'h1);
		cop(0, 1'h0, 19'h40005, 32'h0, d, rs);
		chk("upper_data", d, 32'h0BAD_CAFE);
		cop(2, 1'h1, 19'h00005, 32'h0, d, rs);
		chk("lower_strobe", rs, 2'h2);
		$display("t_bank done");
	endtask : t_bank
	task automatic t_refresh();
		int n;
		wr(ADDR_CTRL, 32'h0000_0208, r);
		for (int k = 0; k < 2; k++) begin
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (!(!cas0 && rsn) && n < 300);
			chk("refresh_seen", n < 300, 1'h1);
			if (k == 1) chk("refresh_gap", n + 2, REFRESH_CYC);
			chk("refresh_we", we0, 1'h1);
			@(posedge clk);
			chk("refresh_ras", rsn, 1'h0);
			@(posedge clk);
			chk("refresh_end", {rsn, cas0}, 2'h3);
		end
		$display("t_refresh done");
	endtask : t_refresh
	task automatic t_style();
		logic [31:0] d;
		logic [1:0] rs;
		strap <= 32'hFFFF_FFFF;
		rst <= 1'h1;
		repeat (6) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		cop(2, 1'h1, 19'h00020, 32'h1111_2222, d, rs);
		wr(ADDR_CTRL, 32'h0000_0201, r);
		cop(2, 1'h1, 19'h00020, 32'h3333_4444, d, rs);
		wr(ADDR_CTRL, 32'h0000_0200, r);
		cop(0, 1'h0, 19'h00020, 32'h0, d, rs);
		chk("lane_mask", d, 32'h1111_4444);
		$display("t_style done");
	endtask : t_style
	initial begin
		#2000000;
		err_count++;
		summarize();
	end
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		t_strap();
		t_regs();
		wr(ADDR_CTRL, 32'h0000_0000, r);
		t_page(2, 1'h1, 1);
		t_page(3, 1'h0, 4);
		wr(ADDR_CTRL, 32'h0000_0008, r);
		t_page(3, 1'h0, 1);
		t_prio();
		t_bank();
		t_refresh();
		t_style();
		summarize();
	end
endmodule : test_display_dram_interface
